// ### voice_irq_defines.svh
// Register map, field positions and reset values of the receive-buffer and interrupt block
`ifndef VOICE_IRQ_DEFINES_SVH
`define VOICE_IRQ_DEFINES_SVH

`define CHAN2_RX_BUFFER_BASE_ADDR 32'hbd280028
`define CHAN3_RX_BUFFER_BASE_ADDR 32'hbd28002c
`define VOICE_IRQ_MASK_ADDR       32'hbd280030
`define VOICE_IRQ_PENDING_ADDR    32'hbd280034

`define RX_BASE_RESET        32'h00000000
`define VOICE_IRQ_RESET      16'h0000
`define RX_PAGE_POINTER_MSB  31
`define RX_PAGE_POINTER_LSB  2
`define PAGE1_OWNER_BIT      1
`define PAGE0_OWNER_BIT      0
`define IRQ_FIELD_WIDTH      16
`define CH2_TX_UNAVAIL_BIT   5
`define CH2_RX_UNAVAIL_BIT   4
`define CH1_PAGE1_DONE_BIT   10
`define CH2_PAGE1_DONE_BIT   6
`define CH3_PAGE0_DONE_BIT   3
`define CH3_RX_UNAVAIL_BIT   0
`define APB_READY_DELAY      1

`endif

// ### voice_irq_pkg.sv
// Types shared by the receive-buffer and interrupt block
`default_nettype none

package voice_irq_pkg;

    // One nibble per channel, top bit first
    typedef struct packed {
        logic page0_done;
        logic page1_done;
        logic tx_unavail;
        logic rx_unavail;
    } chan_event_type;

    // Channel 0 sits in the top nibble
    typedef chan_event_type [0:3] irq_vec_type;

    typedef struct packed {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_type;

endpackage

`default_nettype wire

// ### voice_rx_irq.sv
// Receive base pointers for channels 2 and 3 plus voice interrupt mask and pending registers
//
// Contract
// - Each receive base register keeps the word-aligned buffer start address in bits 31 to 2.
// - Bit 0 of a base register tells who owns page 0: 0 the processor, 1 the controller.
// - Bit 1 of a base register tells who owns page 1: 0 the processor, 1 the controller.
// - The mask holds sixteen enables, a nibble per channel with channel 0 on top.
// - Channel 2 transmit-unavailable enable is mask bit 5 and resets to off.
// - The pending register holds sixteen flags in the mask layout, all clear after reset.
// - A pending flag reads 1 while outstanding and only flags written with 1 are cleared.
// - Each page completion sets its page-done flag; channel 1 page 1 is bit 10.
// - A request for a receive page the controller does not own sets rx-unavailable; ch2 bit 4.
// - Status bit 0 is the channel 3 rx-unavailable flag, cleared by writing 1.
`include "voice_irq_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module voice_rx_irq (
    input  wire logic                       clk_sys,
    input  wire logic                       resetn,
    input  wire voice_irq_pkg::apb_req_type apb_req,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire voice_irq_pkg::irq_vec_type chan_events,
    input  wire logic [1:0]                 rx_page_done_ch2,
    input  wire logic [1:0]                 rx_page_done_ch3,
    input  wire logic [1:0]                 rx_page_need,
    input  wire logic [1:0]                 rx_page_sel,
    output logic [31:0]                     chan2_rx_base,
    output logic [31:0]                     chan3_rx_base,
    output logic                            voice_irq
);

    logic [31:0] chan2_rx_buffer_base;
    logic [31:0] chan3_rx_buffer_base;
    logic [15:0] voice_irq_mask;
    logic [15:0] voice_irq_pending;
    logic [15:0] set_vec;
    logic [15:0] clear_vec;
    logic [15:0] next_pending;
    logic [31:0] next_rdata;
    logic        next_err;
    logic        setup_phase;
    logic        wr_access;
    logic        hit_base2;
    logic        hit_base3;
    logic        hit_mask;
    logic        hit_pend;
    logic [1:0]  owner2;
    logic [1:0]  owner3;
    logic [1:0]  rx_miss;
    logic [1:0]  next_owner2;
    logic [1:0]  next_owner3;
    voice_irq_pkg::irq_vec_type rx_events;

    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign wr_access   = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;
    assign hit_base2   = apb_req.paddr == `CHAN2_RX_BUFFER_BASE_ADDR;
    assign hit_base3   = apb_req.paddr == `CHAN3_RX_BUFFER_BASE_ADDR;
    assign hit_mask    = apb_req.paddr == `VOICE_IRQ_MASK_ADDR;
    assign hit_pend    = apb_req.paddr == `VOICE_IRQ_PENDING_ADDR;
    assign owner2      = chan2_rx_buffer_base[`PAGE1_OWNER_BIT:`PAGE0_OWNER_BIT];
    assign owner3      = chan3_rx_buffer_base[`PAGE1_OWNER_BIT:`PAGE0_OWNER_BIT];

    // A page needed while the processor still owns it is a miss
    assign rx_miss[0] = rx_page_need[0] && !owner2[rx_page_sel[0]];
    assign rx_miss[1] = rx_page_need[1] && !owner3[rx_page_sel[1]];

    always_comb begin
        rx_events                = '0;
        rx_events[2].page0_done  = rx_page_done_ch2[0];
        rx_events[2].page1_done  = rx_page_done_ch2[1];
        rx_events[2].rx_unavail  = rx_miss[0];
        rx_events[3].page0_done  = rx_page_done_ch3[0];
        rx_events[3].page1_done  = rx_page_done_ch3[1];
        rx_events[3].rx_unavail  = rx_miss[1];
    end

    assign set_vec   = 16'(chan_events) | 16'(rx_events);
    // Upper write bits are dropped so reserved bits never clear anything
    assign clear_vec = (wr_access && hit_pend) ? apb_req.pwdata[15:0] : 16'h0000;
    // Set wins over a clear landing in the same cycle
    assign next_pending = (voice_irq_pending & ~clear_vec) | set_vec;

    // Completed pages go back to the processor; a processor write in the same cycle wins
    assign next_owner2 = owner2 & ~rx_page_done_ch2;
    assign next_owner3 = owner3 & ~rx_page_done_ch3;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            chan2_rx_buffer_base <= `RX_BASE_RESET;
        end else if (wr_access && hit_base2) begin
            chan2_rx_buffer_base <= apb_req.pwdata;
        end else begin
            chan2_rx_buffer_base[`PAGE1_OWNER_BIT:`PAGE0_OWNER_BIT] <= next_owner2;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            chan3_rx_buffer_base <= `RX_BASE_RESET;
        end else if (wr_access && hit_base3) begin
            chan3_rx_buffer_base <= apb_req.pwdata;
        end else begin
            chan3_rx_buffer_base[`PAGE1_OWNER_BIT:`PAGE0_OWNER_BIT] <= next_owner3;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            voice_irq_mask <= `VOICE_IRQ_RESET;
        end else if (wr_access && hit_mask) begin
            voice_irq_mask <= apb_req.pwdata[15:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            voice_irq_pending <= `VOICE_IRQ_RESET;
        end else begin
            voice_irq_pending <= next_pending;
        end
    end

    // Line is built from next_pending so it changes on the same edge as pending and leaves a flip-flop
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            voice_irq <= 1'b0;
        end else begin
            voice_irq <= |(next_pending & voice_irq_mask);
        end
    end

    always_comb begin
        next_rdata = 32'h00000000;
        next_err   = 1'b0;
        if (hit_base2) begin
            next_rdata = chan2_rx_buffer_base;
        end else if (hit_base3) begin
            next_rdata = chan3_rx_buffer_base;
        end else if (hit_mask) begin
            next_rdata = {16'h0000, voice_irq_mask};
        end else if (hit_pend) begin
            next_rdata = {16'h0000, voice_irq_pending};
        end else begin
            next_err = 1'b1;
        end
    end

    // Answer is decoded in the setup cycle so access phase needs no wait state
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase && next_err;
            prdata  <= (setup_phase && !apb_req.pwrite) ? next_rdata : 32'h00000000;
        end
    end

    assign chan2_rx_base = chan2_rx_buffer_base;
    assign chan3_rx_base = chan3_rx_buffer_base;

    a_base_store: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_access && hit_base2) |=> chan2_rx_base == $past(apb_req.pwdata))
        else $error("chan2 base did not take written value");

    a_owner_return: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rx_page_done_ch3[0] && !(wr_access && hit_base3)) |=> !chan3_rx_base[0])
        else $error("page 0 owner not returned to processor");

    a_owner_page1: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rx_page_done_ch2[1] && !(wr_access && hit_base2)) |=> !chan2_rx_base[1])
        else $error("page 1 owner not returned to processor");

    a_mask_layout: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_access && hit_mask) |=> voice_irq_mask == $past(apb_req.pwdata[15:0]))
        else $error("mask write mismatch");

    a_tx_en_reset: assert property (@(posedge clk_sys)
        !resetn |=> !voice_irq_mask[`CH2_TX_UNAVAIL_BIT])
        else $error("ch2 tx unavailable enable not off after reset");

    a_pend_reset: assert property (@(posedge clk_sys)
        !resetn |=> voice_irq_pending == 16'h0000 && !voice_irq)
        else $error("pending not clear after reset");

    a_clear_only: assert property (@(posedge clk_sys) disable iff (!resetn)
        1'b1 |=> (($past(voice_irq_pending) & ~$past(clear_vec)) & ~voice_irq_pending) == 0)
        else $error("flag lost without a write of 1");

    a_set_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
        (|set_vec) |=> (voice_irq_pending & $past(set_vec)) == $past(set_vec))
        else $error("event lost");

    a_page_done_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
        chan_events[1].page1_done |=> voice_irq_pending[`CH1_PAGE1_DONE_BIT])
        else $error("ch1 page1 done flag not set");

    a_rx_miss_ch2: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rx_page_need[0] && !owner2[rx_page_sel[0]]) |=> voice_irq_pending[`CH2_RX_UNAVAIL_BIT])
        else $error("ch2 rx unavailable flag not set");

    a_rx_miss_ch3: assert property (@(posedge clk_sys) disable iff (!resetn)
        (voice_irq_pending[`CH3_RX_UNAVAIL_BIT] && !set_vec[0]
            && wr_access && hit_pend && apb_req.pwdata[0])
            |=> !voice_irq_pending[`CH3_RX_UNAVAIL_BIT])
        else $error("ch3 rx unavailable flag not cleared");

    a_irq_level: assert property (@(posedge clk_sys) disable iff (!resetn)
        ##1 voice_irq == |($past(next_pending) & $past(voice_irq_mask)))
        else $error("interrupt line disagrees with pending and mask");

    a_upper_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (setup_phase && !apb_req.pwrite && (hit_mask || hit_pend)) |=> prdata[31:16] == 16'h0000)
        else $error("reserved bits read nonzero");

    a_apb_ready: assert property (@(posedge clk_sys) disable iff (!resetn)
        setup_phase |=> pready ##1 !pready)
        else $error("pready timing wrong");

    a_base3_store: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_access && hit_base3) |=> chan3_rx_base == $past(apb_req.pwdata))
        else $error("chan3 base did not take written value");

    a_ptr2_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(wr_access && hit_base2) |=> chan2_rx_base[31:2] == $past(chan2_rx_base[31:2]))
        else $error("chan2 pointer changed without a write");

    a_ptr3_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(wr_access && hit_base3) |=> chan3_rx_base[31:2] == $past(chan3_rx_base[31:2]))
        else $error("chan3 pointer changed without a write");

    a_base_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        (setup_phase && !apb_req.pwrite && hit_base3) |=> prdata == $past(chan3_rx_buffer_base))
        else $error("chan3 base read back wrong");

    a_owner0_ch2: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rx_page_done_ch2[0] && !(wr_access && hit_base2)) |=> !chan2_rx_base[0])
        else $error("ch2 page 0 owner not returned to processor");

    a_owner0_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!rx_page_done_ch2[0] && !(wr_access && hit_base2)) |=> $stable(chan2_rx_base[0]))
        else $error("ch2 page 0 owner changed on its own");

    a_owner1_ch3: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rx_page_done_ch3[1] && !(wr_access && hit_base3)) |=> !chan3_rx_base[1])
        else $error("ch3 page 1 owner not returned to processor");

    a_owner1_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!rx_page_done_ch3[1] && !(wr_access && hit_base3)) |=> $stable(chan3_rx_base[1]))
        else $error("ch3 page 1 owner changed on its own");

    a_mask_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(wr_access && hit_mask) |=> $stable(voice_irq_mask))
        else $error("mask changed without a write");

    a_tx_en_store: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_access && hit_mask) |=> voice_irq_mask[`CH2_TX_UNAVAIL_BIT] == $past(apb_req.pwdata[5]))
        else $error("ch2 tx unavailable enable not stored");

    // A flag may only appear where an event was seen the cycle before
    a_no_spurious: assert property (@(posedge clk_sys) disable iff (!resetn)
        1'b1 |=> (voice_irq_pending & ~$past(voice_irq_pending) & ~$past(set_vec)) == 16'h0000)
        else $error("pending flag set without an event");

    a_pend_readback: assert property (@(posedge clk_sys) disable iff (!resetn)
        (setup_phase && !apb_req.pwrite && hit_pend) |=> prdata[15:0] == $past(voice_irq_pending))
        else $error("pending read back wrong");

    a_ch2_page_done: assert property (@(posedge clk_sys) disable iff (!resetn)
        rx_page_done_ch2[1] |=> voice_irq_pending[`CH2_PAGE1_DONE_BIT])
        else $error("ch2 page1 done flag not set");

    a_ch3_page_done: assert property (@(posedge clk_sys) disable iff (!resetn)
        rx_page_done_ch3[0] |=> voice_irq_pending[`CH3_PAGE0_DONE_BIT])
        else $error("ch3 page0 done flag not set");

    a_rx_miss3_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rx_page_need[1] && !owner3[rx_page_sel[1]]) |=> voice_irq_pending[`CH3_RX_UNAVAIL_BIT])
        else $error("ch3 rx unavailable flag not set");

    a_irq_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(|(next_pending & voice_irq_mask)) |=> !voice_irq)
        else $error("interrupt line high with nothing enabled pending");

    a_err_unmapped: assert property (@(posedge clk_sys) disable iff (!resetn)
        (setup_phase && next_err) |=> pslverr && pready)
        else $error("unmapped access not flagged");

    a_err_mapped: assert property (@(posedge clk_sys) disable iff (!resetn)
        (setup_phase && !next_err) |=> !pslverr)
        else $error("mapped access flagged as error");

    // Read data is forced to zero outside the answer cycle
    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        !setup_phase |=> prdata == 32'h00000000)
        else $error("read data not zero outside answer");

endmodule // voice_rx_irq

`default_nettype wire

// ### voice_engine_model.sv
// Behavioural model of the PCM engine that raises events toward the block
`timescale 1ns/1ns
`default_nettype none

module voice_engine_model (
    input  wire logic                  clk_sys,
    input  wire logic [15:0]           ev_cmd,
    input  wire logic [3:0]            done_cmd,
    input  wire logic [3:0]            need_cmd,
    output var voice_irq_pkg::irq_vec_type chan_events,
    output logic [1:0]                 rx_page_done_ch2,
    output logic [1:0]                 rx_page_done_ch3,
    output logic [1:0]                 rx_page_need,
    output logic [1:0]                 rx_page_sel
);
    // Commands are registered one edge later; an event stays high for as long as its command is held
    always @(posedge clk_sys) begin
        chan_events <= voice_irq_pkg::irq_vec_type'(ev_cmd);
        {rx_page_done_ch3, rx_page_done_ch2} <= done_cmd;
        rx_page_need <= need_cmd[1:0];
        // Select is meaningless without a need pulse, so it flips while idle
        rx_page_sel <= (|need_cmd[1:0]) ? need_cmd[3:2] : ~need_cmd[3:2];
    end
endmodule // voice_engine_model
`default_nettype wire

// ### test_pcm_rx_buffer_and_interrupts.sv
// Self-checking bench for the receive-buffer and voice interrupt block
`timescale 1ns/1ns
`default_nettype none
`include "voice_irq_defines.svh"

module test_pcm_rx_buffer_and_interrupts;
    localparam logic [31:0] base2 = `CHAN2_RX_BUFFER_BASE_ADDR;
    localparam logic [31:0] base3 = `CHAN3_RX_BUFFER_BASE_ADDR;
    localparam logic [31:0] mask  = `VOICE_IRQ_MASK_ADDR;
    localparam logic [31:0] pend  = `VOICE_IRQ_PENDING_ADDR;

    logic                       clk_sys  = 1'b0;
    logic                       resetn   = 1'b0;
    voice_irq_pkg::apb_req_type req      = '0;
    logic [15:0]                ev_cmd   = '0;
    logic [3:0]                 done_cmd = '0;
    logic [3:0]                 need_cmd = '0;
    logic [31:0]                prdata, chan2_rx_base, chan3_rx_base, rdata;
    logic                       pready, pslverr, voice_irq, rerr;
    voice_irq_pkg::irq_vec_type chan_events;
    logic [1:0]                 pd2, pd3, need, sel;
    int                         fails = 0;
    int                         check_count = 0;
    int                         cycles = 0;

    always #20 clk_sys = ~clk_sys;

    voice_engine_model engine (
        .clk_sys(clk_sys), .ev_cmd(ev_cmd), .done_cmd(done_cmd), .need_cmd(need_cmd),
        .chan_events(chan_events), .rx_page_done_ch2(pd2), .rx_page_done_ch3(pd3),
        .rx_page_need(need), .rx_page_sel(sel)
    );

    voice_rx_irq DUT (
        .clk_sys(clk_sys), .resetn(resetn), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan_events(chan_events),
        .rx_page_done_ch2(pd2), .rx_page_done_ch3(pd3), .rx_page_need(need),
        .rx_page_sel(sel), .chan2_rx_base(chan2_rx_base),
        .chan3_rx_base(chan3_rx_base), .voice_irq(voice_irq)
    );

    task complete_run;
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge
    task apb(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{a, 1'b1, 1'b0, w, d};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // Outputs updated at the answer edge are looked at once settled
        @(negedge clk_sys);
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task rd(input string name, input logic [31:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(name, exp, rdata);
        chk("pslverr", 32'h0, {31'h0, rerr});
    endtask

    // Issues one engine pulse and waits until the block has taken it
    task ev(input logic [15:0] e, input logic [3:0] dn, input logic [3:0] nd);
        @(posedge clk_sys);
        ev_cmd <= e;
        done_cmd <= dn;
        need_cmd <= nd;
        @(posedge clk_sys);
        ev_cmd <= '0;
        done_cmd <= '0;
        need_cmd <= '0;
        repeat (2) @(posedge clk_sys);
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            complete_run;
        end
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        rd("base2", base2, 32'h0);
        rd("base3", base3, 32'h0);
        rd("mask", mask, 32'h0);
        rd("pending", pend, 32'h0);
        wr(base2, 32'hdeadbee3);
        rd("base2", base2, 32'hdeadbee3);
        chk("chan2_rx_base", 32'hdeadbee3, chan2_rx_base);
        wr(base3, 32'h12345678);
        chk("chan3_rx_base", 32'h12345678, chan3_rx_base);
        wr(mask, 32'hffff0020);
        rd("mask", mask, 32'h00000020);
        for (int i = 0; i < 16; i++) begin
            ev(16'h1 << i, 4'h0, 4'h0);
            rd("pending", pend, 32'h1 << i);
            chk("voice_irq", {31'h0, i == 5}, {31'h0, voice_irq});
            wr(pend, 32'hffff0000 | (32'h1 << i));
            rd("pending", pend, 32'h0);
        end
        ev(16'h0401, 4'h0, 4'h0);
        wr(pend, 32'h00000400);
        rd("pending", pend, 32'h00000001);
        wr(pend, 32'h00000001);
        ev(16'h0, 4'h0, 4'b0010);
        ev(16'h0, 4'h0, 4'b0101);
        rd("pending", pend, 32'h00000001);
        ev(16'h0, 4'b0010, 4'h0);
        rd("base2", base2, 32'hdeadbee1);
        ev(16'h0, 4'h0, 4'b0101);
        rd("pending", pend, 32'h00000051);
        chk("voice_irq", 32'h0, {31'h0, voice_irq});
        wr(mask, 32'h00000010);
        rd("mask", mask, 32'h00000010);
        chk("voice_irq", 32'h1, {31'h0, voice_irq});
        wr(pend, 32'hffffffff);
        rd("pending", pend, 32'h0);
        chk("voice_irq", 32'h0, {31'h0, voice_irq});
        apb(pend + 32'h4, 1'b0, 32'h0);
        chk("pslverr", 32'h1, {31'h0, rerr});
        chk("prdata", 32'h0, rdata);
        complete_run;
    end
endmodule // test_pcm_rx_buffer_and_interrupts
`default_nettype wire
